/* hdl/ufc_pkg.sv */
package ufc_pkg;
  // receive trigger selections
  localparam logic [1:0] TRIG_1  = 2'h0;
  localparam logic [1:0] TRIG_4  = 2'h1;
  localparam logic [1:0] TRIG_8  = 2'h2;
  localparam logic [1:0] TRIG_14 = 2'h3;
  localparam logic [4:0] LVL_1   = 5'h01;
  localparam logic [4:0] LVL_4   = 5'h04;
  localparam logic [4:0] LVL_8   = 5'h08;
  localparam logic [4:0] LVL_14  = 5'h0E;
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  // enhanced feature control bit positions
  localparam int EFC_SPECIAL  = 5;
  localparam int EFC_AUTORTS  = 6;
  localparam int EFC_AUTOCTS  = 7;
  // interrupt enable bit positions
  localparam int IEN_XOFF = 5;
  localparam int IEN_RTS  = 6;
  localparam int IEN_CTS  = 7;
  localparam logic [7:0] CHAR_RST = 8'h00;
  localparam logic [3:0] TOUT_CHARS = 4'h4;
  localparam logic [4:0] DATA_FIRST_TICK = 5'h18;
  // interrupt source codes, highest first
  localparam logic [2:0] SRC_NONE = 3'h0;
  localparam logic [2:0] SRC_TOUT = 3'h1;
  localparam logic [2:0] SRC_XOFF = 3'h2;
  localparam logic [2:0] SRC_CTS  = 3'h3;
  localparam logic [2:0] SRC_RTS  = 3'h4;
  typedef enum logic [1:0] {
    UFC_SW_IDLE = 2'b00,
    UFC_SW_HALF = 2'b01,
    UFC_SW_STOP = 2'b11
  } ufc_sw_t;
endpackage : ufc_pkg

/* hdl/ufc_fifo.sv */
`timescale 1ns/1ps
module ufc_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         mclk_i,
  input  wire logic         rstn_i,
  // fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o,
  output logic [$clog2(D):0] count_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_reg [D];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0]   cnt_reg;
  wire push = in_valid_i & in_ready_o;
  wire pop  = out_valid_o & out_ready_i;
  assign in_ready_o  = (cnt_reg != (AW+1)'(D));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o  = mem_reg[rd_reg];
  assign count_o     = cnt_reg;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wr_reg <= (wr_reg == AW'(D-1)) ? '0 : wr_reg + 1'b1;
      if (pop) rd_reg <= (rd_reg == AW'(D-1)) ? '0 : rd_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge mclk_i) begin
    if (push) mem_reg[wr_reg] <= in_data_i;
  end
  fifo_no_over_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    cnt_reg <= (AW+1)'(D)) else $error("fifo count above depth");
endmodule : ufc_fifo

/* hdl/ufc_flow.sv */
`timescale 1ns/1ps
// Behaviour
// - at trigger 1, 4 or 8, drop request-to-send when fill reaches it
// - keep accepting one more character after request-to-send drops
// - for 1, 4, 8, raise request-to-send once reads empty the FIFO, or on a read from a full FIFO
// - at trigger 14, drop at first data bit of sixteenth character
// - at 14, raise when one slot free and idle, or two free
// - with FIFO full, first host read raises request-to-send
// - auto clear-to-send samples before each character, sends while low
// - clear-to-send high before last stop middle holds next character
// - transmitter resumes when clear-to-send returns low
// - no clear-to-send interrupts while automatic flow control is on
// - bits 6 and 7 of enhanced feature control enable autoflow
// - stop-character match halts transmission after current character
// - stop match sets flow status and interrupt when enabled
// - while stopped, resume-character match restarts and clears flag
// - reset clears four character registers to zero
// - double mode needs two consecutive characters matching the pair; code compares the resume pair's second with off2, not on2
// - consumed flow-control characters are not stored in the FIFO
// - send stop characters at or above trigger, resume characters below it
// - special enable stores second-stop match and sets special flag
// - comparisons use configured word length, bit 0 is first bit
// - interrupt enable bits 5-7; modem-line sources lowest priority
// - time-out after 4 character times, restarts, never when empty
module ufc_flow #(
  parameter int DEPTH = 16,
  parameter int TXQ   = 8
) (
  input  wire logic       mclk_i,
  input  wire logic       rstn_i,
  // configuration
  input  wire logic [7:0] enhanced_feature_ctrl_i,
  input  wire logic [7:0] interrupt_enable_reg_i,
  input  wire logic [1:0] line_control_reg_i,
  input  wire logic [1:0] trig_sel_i,
  input  wire logic       double_char_i,
  input  wire logic       sw_rx_en_i,
  input  wire logic       sw_tx_en_i,
  input  wire logic [3:0] char_bits_i,
  // character register writes
  input  wire logic       char_we_i,
  input  wire logic [1:0] char_sel_i,
  input  wire logic [7:0] char_wdata_i,
  // receiver events
  input  wire logic       rx_valid_i,
  input  wire logic [7:0] rx_data_i,
  input  wire logic       rx_busy_i,
  input  wire logic [4:0] rx_tick_i,
  input  wire logic       rx_stop_mid_i,
  input  wire logic       tick16_i,
  // host receive buffer
  input  wire logic       rhb_read_i,
  output logic [7:0]      receive_holding_buffer_o,
  output logic            rhb_valid_o,
  output logic [4:0]      rx_level_o,
  // host transmit queue
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o,
  input  wire logic [7:0] tx_data_i,
  // transmitter
  input  wire logic       tx_idle_i,
  input  wire logic       tx_stop_mid_i,
  output logic            tx_start_o,
  output logic [7:0]      tx_char_o,
  // modem lines
  input  wire logic       cts_n_i,
  output logic            rts_n_o,
  // status and interrupt
  output logic            flow_flag_o,
  output logic            special_flag_o,
  output logic [2:0]      interrupt_source_reg_o,
  output logic            irq_o
);
  logic [7:0] chars_reg [4];
  logic [4:0] lvl_reg;
  logic       rts_n_reg;
  logic       cts_hold_reg;
  logic       cts_prev_reg;
  logic       cts_chg_reg;
  logic       rts_chg_reg;
  logic       rts_prev_reg;
  logic       flow_reg;
  logic       spec_reg;
  logic       sent_stop_reg;
  logic       pend_reg;
  logic [1:0] pend_idx_reg;
  logic [7:0] cmp_mask;
  logic [7:0] dat_reg;
  logic       dat_v_reg;
  logic       tx_start_reg;
  logic [7:0] tx_char_reg;
  logic [9:0] tout_reg;
  logic       tout_reg_f;
  logic [9:0] tout_lim;
  ufc_pkg::ufc_sw_t sw_reg;
  ufc_pkg::ufc_sw_t sw_next;

  // reset clears the character registers
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < 4; i++) chars_reg[i] <= ufc_pkg::CHAR_RST;
    end else if (char_we_i) begin
      chars_reg[char_sel_i] <= char_wdata_i;
    end
  end
  wire [7:0] on1  = chars_reg[0];
  wire [7:0] on2  = chars_reg[1];
  wire [7:0] off1 = chars_reg[2];
  wire [7:0] off2 = chars_reg[3];

  // compare mask from word length
  assign cmp_mask = 8'hFF >> (2'h3 - line_control_reg_i);
  wire [7:0] rxm  = rx_data_i & cmp_mask;
  wire m_on1  = rxm == (on1 & cmp_mask);
  wire m_on2  = rxm == (on2 & cmp_mask);
  wire m_off1 = rxm == (off1 & cmp_mask);
  wire m_off2 = rxm == (off2 & cmp_mask);
  wire autorts = enhanced_feature_ctrl_i[ufc_pkg::EFC_AUTORTS];
  wire autocts = enhanced_feature_ctrl_i[ufc_pkg::EFC_AUTOCTS];
  wire special = enhanced_feature_ctrl_i[ufc_pkg::EFC_SPECIAL];

  // software flow detection
  wire stopped = (sw_reg == ufc_pkg::UFC_SW_STOP);
  wire first_on  = stopped ? m_on1 : m_off1;
  wire second_on = stopped ? m_on2 : m_off2;
  wire half = (sw_reg == ufc_pkg::UFC_SW_HALF);
  wire hit_one = sw_rx_en_i & rx_valid_i & ~double_char_i & first_on;
  wire hit_two = sw_rx_en_i & rx_valid_i & double_char_i & half
                 & second_on;
  wire hit_start = sw_rx_en_i & rx_valid_i & double_char_i & first_on
                   & (sw_reg != ufc_pkg::UFC_SW_HALF);
  wire hit = hit_one | hit_two;
  wire consumed = hit | hit_start;
  logic stop_ctx_reg;
  always_comb begin
    sw_next = sw_reg;
    case (sw_reg)
      ufc_pkg::UFC_SW_IDLE: begin
        if (hit_one) sw_next = ufc_pkg::UFC_SW_STOP;
        else if (hit_start) sw_next = ufc_pkg::UFC_SW_HALF;
      end
      ufc_pkg::UFC_SW_HALF: begin
        if (rx_valid_i)
          sw_next = hit_two ? (stop_ctx_reg ? ufc_pkg::UFC_SW_IDLE
                                            : ufc_pkg::UFC_SW_STOP)
                            : (stop_ctx_reg ? ufc_pkg::UFC_SW_STOP
                                            : ufc_pkg::UFC_SW_IDLE);
      end
      ufc_pkg::UFC_SW_STOP: begin
        if (hit_one) sw_next = ufc_pkg::UFC_SW_IDLE;
        else if (hit_start) sw_next = ufc_pkg::UFC_SW_HALF;
      end
      default: sw_next = ufc_pkg::UFC_SW_IDLE;
    endcase
    if (!sw_rx_en_i) sw_next = ufc_pkg::UFC_SW_IDLE;
  end
  wire xoff_hit = hit & ~(half ? stop_ctx_reg : stopped);
  wire xon_hit  = hit & (half ? stop_ctx_reg : stopped);
  wire spec_hit = special & rx_valid_i & m_off2;

  // receive fifo
  logic rx_in_ready;
  ufc_fifo #(.W(8), .D(DEPTH)) u_rx (
    .mclk_i      (mclk_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (rx_valid_i & ~consumed),
    .in_ready_o  (rx_in_ready),
    .in_data_i   (rx_data_i),
    .out_valid_o (rhb_valid_o),
    .out_ready_i (rhb_read_i),
    .out_data_o  (receive_holding_buffer_o),
    .count_o     (rx_level_o)
  );

  // threshold selection
  always_comb begin
    case (trig_sel_i)
      ufc_pkg::TRIG_1: lvl_reg = ufc_pkg::LVL_1;
      ufc_pkg::TRIG_4: lvl_reg = ufc_pkg::LVL_4;
      ufc_pkg::TRIG_8: lvl_reg = ufc_pkg::LVL_8;
      default:         lvl_reg = ufc_pkg::LVL_14;
    endcase
  end
  wire is14 = trig_sel_i == ufc_pkg::TRIG_14;
  wire [4:0] free = ufc_pkg::FIFO_DEPTH - rx_level_o;
  wire at_trig = rx_level_o >= lvl_reg;
  // sixteenth character: fifo holds 15, first data bit seen
  wire rx16 = (rx_level_o == ufc_pkg::FIFO_DEPTH - 5'h01) & rx_busy_i
              & (rx_tick_i >= ufc_pkg::DATA_FIRST_TICK);
  wire full_read = (rx_level_o == ufc_pkg::FIFO_DEPTH) & rhb_read_i;
  wire drop_lo = ~is14 & at_trig;
  wire raise_lo = ~is14 & (rx_level_o == 5'h00);
  wire drop_14 = is14 & (rx16 | free == 5'h00);
  // the completing character still counts as in progress
  wire raise_14 = is14 & ((free >= 5'h01 & ~rx_busy_i & ~rx_valid_i)
                  | free > 5'h01);
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rts_n_reg <= 1'b0;
    end else if (!autorts) begin
      rts_n_reg <= 1'b0;
    end else if (full_read) begin
      rts_n_reg <= 1'b0;
    end else if (drop_lo | drop_14) begin
      rts_n_reg <= 1'b1;
    end else if (raise_lo | raise_14) begin
      rts_n_reg <= 1'b0;
    end
  end
  assign rts_n_o = rts_n_reg;
  // fifo still takes the late character when rts has dropped
  rx_late_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (rts_n_o && !is14 && rx_level_o < ufc_pkg::FIFO_DEPTH) |-> rx_in_ready)
    else $error("late character refused");
  rts_drop_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (autorts && !is14 && at_trig && !rhb_read_i) |=> rts_n_o)
    else $error("rts not dropped at trigger");
  rts_full_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (autorts && full_read) |=> !rts_n_o)
    else $error("full read did not raise rts");
  rts_empty_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (autorts && !is14 && $past(rx_level_o) != 0 && rx_level_o != 0
     && !$past(full_read) && $past(rts_n_o)) |-> rts_n_o)
    else $error("rts raised before empty");
  rts_late14_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (autorts && is14 && rx16) |=> rts_n_o)
    else $error("rts not dropped on sixteenth");
  rts_rearm14_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (autorts && raise_14) |=> !rts_n_o)
    else $error("rts not raised with free slot");

  // transmit queue and gate
  logic [7:0] q_data;
  logic       q_valid;
  logic       q_pop;
  ufc_fifo #(.W(8), .D(TXQ)) u_tx (
    .mclk_i      (mclk_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (tx_valid_i),
    .in_ready_o  (tx_ready_o),
    .in_data_i   (tx_data_i),
    .out_valid_o (q_valid),
    .out_ready_i (q_pop),
    .out_data_o  (q_data),
    .count_o     ()
  );
  // clear-to-send sampled at last stop middle and while idle
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cts_hold_reg <= 1'b0;
    end else if (tx_stop_mid_i | tx_idle_i) begin
      cts_hold_reg <= autocts & cts_n_i;
    end
  end
  wire tx_hold_sw = sw_tx_en_i & stopped;
  wire cts_go = ~cts_hold_reg & ~(autocts & cts_n_i);
  // pending flow characters to send
  wire want_off = sw_tx_en_i & at_trig & ~sent_stop_reg;
  wire want_on  = sw_tx_en_i & ~at_trig & sent_stop_reg;
  wire can_start = tx_idle_i & ~tx_start_reg & cts_go;
  wire send_ctl = can_start & (pend_reg | want_off | want_on);
  assign q_pop = can_start & ~send_ctl & ~tx_hold_sw & q_valid;
  wire [1:0] next_ctl = pend_reg ? pend_idx_reg
                        : (want_off ? 2'h2 : 2'h0);
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_start_reg  <= 1'b0;
      tx_char_reg   <= 8'h00;
      sent_stop_reg <= 1'b0;
      pend_reg      <= 1'b0;
      pend_idx_reg  <= 2'h0;
    end else begin
      tx_start_reg <= send_ctl | q_pop;
      if (send_ctl) begin
        tx_char_reg <= chars_reg[next_ctl];
        if (!pend_reg) sent_stop_reg <= want_off;
        pend_reg <= ~pend_reg & double_char_i;
        pend_idx_reg <= next_ctl + 2'h1;
      end else if (q_pop) begin
        tx_char_reg <= q_data;
      end
    end
  end
  assign tx_start_o = tx_start_reg;
  assign tx_char_o  = tx_char_reg;
  cts_block_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (autocts && cts_n_i && tx_idle_i) |=> !tx_start_o)
    else $error("character sent while cts high");
  sw_halt_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (sw_tx_en_i && stopped) |-> !q_pop)
    else $error("data sent while stopped");
  sw_nostart_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (sw_tx_en_i && stopped && !send_ctl) |=> !tx_start_o)
    else $error("start while stopped");
  stop_char_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (send_ctl && !pend_reg && want_off) |=> tx_char_o == off1)
    else $error("wrong stop character sent");

  // state, flags and time-out
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sw_reg       <= ufc_pkg::UFC_SW_IDLE;
      stop_ctx_reg <= 1'b0;
      flow_reg     <= 1'b0;
      spec_reg     <= 1'b0;
      cts_prev_reg <= 1'b0;
      cts_chg_reg  <= 1'b0;
      rts_chg_reg  <= 1'b0;
      rts_prev_reg <= 1'b0;
      tout_reg     <= '0;
      tout_reg_f   <= 1'b0;
      dat_reg      <= 8'h00;
      dat_v_reg    <= 1'b0;
    end else begin
      sw_reg <= sw_next;
      if (hit_start) stop_ctx_reg <= stopped;
      if (xoff_hit) flow_reg <= 1'b1;
      else if (xon_hit) flow_reg <= 1'b0;
      if (spec_hit) spec_reg <= 1'b1;
      else if (rhb_read_i) spec_reg <= 1'b0;
      cts_prev_reg <= cts_n_i;
      if ((cts_prev_reg != cts_n_i) & ~autocts) cts_chg_reg <= 1'b1;
      else if (rhb_read_i) cts_chg_reg <= 1'b0;
      rts_prev_reg <= rts_n_reg;
      if (rts_prev_reg != rts_n_reg) rts_chg_reg <= 1'b1;
      else if (rhb_read_i) rts_chg_reg <= 1'b0;
      dat_reg   <= rx_data_i;
      dat_v_reg <= rx_valid_i;
      if (rx_stop_mid_i | rhb_read_i | !rhb_valid_o) begin
        tout_reg   <= '0;
        tout_reg_f <= 1'b0;
      end else if (tick16_i & ~tout_reg_f) begin
        if (tout_reg == tout_lim) tout_reg_f <= 1'b1;
        else tout_reg <= tout_reg + 10'h001;
      end
    end
  end
  // four character times of start, data, parity and stop, in 16x ticks
  assign tout_lim = 10'(ufc_pkg::TOUT_CHARS) * 10'(char_bits_i) * 10'h010;
  tout_empty_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !rhb_valid_o |=> !tout_reg_f)
    else $error("time-out with empty fifo");
  xoff_flag_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    xoff_hit |=> flow_flag_o)
    else $error("stop match did not set flag");
  xon_clear_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    xon_hit |=> !flow_flag_o)
    else $error("resume match did not clear flag");
  spec_flag_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    spec_hit |=> special_flag_o)
    else $error("special match not flagged");
  cts_quiet_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (autocts && !cts_chg_reg) |=> !cts_chg_reg)
    else $error("cts change flagged under autoflow");

  // priority: time-out, stop match, then clear and request lines
  wire en_x = interrupt_enable_reg_i[ufc_pkg::IEN_XOFF];
  wire en_r = interrupt_enable_reg_i[ufc_pkg::IEN_RTS];
  wire en_c = interrupt_enable_reg_i[ufc_pkg::IEN_CTS];
  wire [2:0] src = tout_reg_f ? ufc_pkg::SRC_TOUT
                 : ((flow_reg | spec_reg) & en_x) ? ufc_pkg::SRC_XOFF
                 : (cts_chg_reg & en_c) ? ufc_pkg::SRC_CTS
                 : (rts_chg_reg & en_r) ? ufc_pkg::SRC_RTS
                 : ufc_pkg::SRC_NONE;
  assign interrupt_source_reg_o = src;
  assign irq_o          = src != ufc_pkg::SRC_NONE;
  irq_prio_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (!tout_reg_f && flow_reg && en_x && cts_chg_reg && en_c)
    |-> interrupt_source_reg_o == ufc_pkg::SRC_XOFF)
    else $error("modem line source not masked");
  assign flow_flag_o    = flow_reg;
  assign special_flag_o = spec_reg;
endmodule : ufc_flow

/* dv/ufc_remote.sv */
`timescale 1ns/1ps
module ufc_remote #(
  parameter int CHAR_CYC = 12
) (
  input  wire logic       mclk_i,
  input  wire logic       rstn_i,
  // transmitter line
  input  wire logic       tx_start_i,
  input  wire logic [7:0] tx_char_i,
  output logic            tx_idle_o,
  output logic            tx_stop_mid_o,
  // remote side
  input  wire logic       hold_i,
  output logic            cts_n_o,
  output logic [7:0]      sent_cnt_o,
  output logic [7:0]      last_char_o
);
  logic [7:0] bit_cnt_reg;

  // one character occupies the line for CHAR_CYC cycles
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bit_cnt_reg <= 8'h00;
      sent_cnt_o  <= 8'h00;
      last_char_o <= 8'h00;
      cts_n_o     <= 1'h0;
    end else begin
      cts_n_o <= hold_i;
      if (tx_start_i && bit_cnt_reg == 8'h00) begin
        bit_cnt_reg <= CHAR_CYC[7:0];
        sent_cnt_o  <= sent_cnt_o + 8'h01;
        last_char_o <= tx_char_i;
      end else if (bit_cnt_reg != 8'h00) begin
        bit_cnt_reg <= bit_cnt_reg - 8'h01;
      end
    end
  end

  assign tx_idle_o     = (bit_cnt_reg == 8'h00);
  assign tx_stop_mid_o = (bit_cnt_reg == 8'h03);
endmodule : ufc_remote

/* dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic        mclk_i = 1'h0;
  logic        rstn_i = 1'h0;
  logic [7:0]  efc = 8'h00, interrupt_enable_reg = 8'h00, cw = 8'h00, rxd = 8'h00;
  logic [7:0]  txd = 8'h00;
  logic [1:0]  line_control_reg = 2'h3, trig = 2'h0, csel = 2'h0;
  logic        dbl = 1'h0, swrx = 1'h0, swtx = 1'h0, cwe = 1'h0;
  logic        rxv = 1'h0, rxb = 1'h0, smid = 1'h0, rd = 1'h0;
  logic        txv = 1'h0, hold = 1'h0;
  logic [4:0]  tick = 5'h00;
  wire logic [7:0] head, tch, sent, last;
  wire logic [4:0] lvl;
  wire logic [2:0] src;
  wire logic   hv, txr, idle, tmid, tst, cts_n, rts_n, ff, sf, irq;
  int          fail_count = 0, tests_run = 0, cyc = 0, k = 0, s0 = 0;
  logic [31:0] seed = 32'h0000BBF9;
  logic [7:0]  q[$];
  logic [1:0]  trl[3] = '{ufc_pkg::TRIG_1, ufc_pkg::TRIG_4, ufc_pkg::TRIG_8};

  ufc_flow #(.DEPTH(16), .TXQ(8)) uut (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .enhanced_feature_ctrl_i(efc),
    .interrupt_enable_reg_i(interrupt_enable_reg), .line_control_reg_i(line_control_reg),
    .trig_sel_i(trig), .double_char_i(dbl), .sw_rx_en_i(swrx),
    .sw_tx_en_i(swtx), .char_bits_i(4'h2), .char_we_i(cwe),
    .char_sel_i(csel), .char_wdata_i(cw), .rx_valid_i(rxv),
    .rx_data_i(rxd), .rx_busy_i(rxb), .rx_tick_i(tick),
    .rx_stop_mid_i(smid), .tick16_i(1'h1), .rhb_read_i(rd),
    .receive_holding_buffer_o(head), .rhb_valid_o(hv), .rx_level_o(lvl),
    .tx_valid_i(txv), .tx_ready_o(txr), .tx_data_i(txd),
    .tx_idle_i(idle), .tx_stop_mid_i(tmid), .tx_start_o(tst),
    .tx_char_o(tch), .cts_n_i(cts_n), .rts_n_o(rts_n), .flow_flag_o(ff),
    .special_flag_o(sf), .interrupt_source_reg_o(src), .irq_o(irq));

  ufc_remote remote (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .tx_start_i(tst), .tx_char_i(tch),
    .tx_idle_o(idle), .tx_stop_mid_o(tmid), .hold_i(hold),
    .cts_n_o(cts_n), .sent_cnt_o(sent), .last_char_o(last));

  always #10 mclk_i = ~mclk_i;

  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      finish_test();
    end
  end

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd

  function automatic logic [4:0] lvl_of(input logic [1:0] t);
    case (t)
      ufc_pkg::TRIG_1: lvl_of = ufc_pkg::LVL_1;
      ufc_pkg::TRIG_4: lvl_of = ufc_pkg::LVL_4;
      ufc_pkg::TRIG_8: lvl_of = ufc_pkg::LVL_8;
      default:         lvl_of = ufc_pkg::LVL_14;
    endcase
  endfunction : lvl_of

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test

  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : step

  task automatic cfg(input logic [7:0] e, input logic [7:0] i,
                     input logic [1:0] t, input logic d, sr, st);
    @(posedge mclk_i);
    rstn_i <= 1'h0;
    efc    <= e;
    interrupt_enable_reg    <= i;
    trig   <= t;
    dbl    <= d;
    swrx   <= sr;
    swtx   <= st;
    line_control_reg    <= 2'h3;
    hold   <= 1'h0;
    q.delete();
    repeat (8) @(posedge mclk_i);
    rstn_i <= 1'h1;
  endtask : cfg

  task automatic wchar(input logic [1:0] s, input logic [7:0] d);
    @(posedge mclk_i);
    cwe  <= 1'h1;
    csel <= s;
    cw   <= d;
    @(posedge mclk_i);
    cwe  <= 1'h0;
  endtask : wchar

  task automatic rx_begin();
    @(posedge mclk_i);
    rxb  <= 1'h1;
    tick <= ufc_pkg::DATA_FIRST_TICK;
  endtask : rx_begin

  task automatic rx_end(input logic [7:0] d);
    @(posedge mclk_i);
    smid <= 1'h1;
    @(posedge mclk_i);
    smid <= 1'h0;
    rxv  <= 1'h1;
    rxd  <= d;
    rxb  <= 1'h0;
    tick <= 5'h00;
    @(posedge mclk_i);
    rxv  <= 1'h0;
    step(2);
  endtask : rx_end

  task automatic rx_char(input logic [7:0] d);
    rx_begin();
    rx_end(d);
  endtask : rx_char

  task automatic rd_pop();
    @(posedge mclk_i);
    rd <= 1'h1;
    @(posedge mclk_i);
    rd <= 1'h0;
    step(2);
  endtask : rd_pop

  task automatic tx_push(input logic [7:0] d);
    @(posedge mclk_i);
    txv <= 1'h1;
    txd <= d;
    @(posedge mclk_i);
    for (int n = 0; n < 50 && txr !== 1'h1; n++) @(posedge mclk_i);
    txv <= 1'h0;
  endtask : tx_push

  initial begin
    // thresholds 1, 4 and 8 with one extra character
    foreach (trl[n]) begin
      cfg(8'hC0, 8'h00, trl[n], 1'h0, 1'h0, 1'h0);
      k = int'(lvl_of(trl[n]));
      for (int i = 0; i <= k; i++) begin
        q.push_back(rnd());
        rx_char(q[i]);
        check(rts_n, i + 1 >= k);
      end
      check(lvl, 8'(k + 1));
      for (int i = 0; i <= k; i++) begin
        check(head, q.pop_front());
        rd_pop();
        check(rts_n, i < k);
      end
    end
    cfg(8'hC0, 8'h00, ufc_pkg::TRIG_14, 1'h0, 1'h0, 1'h0);
    for (int i = 0; i < 15; i++) begin
      rx_char(rnd());
      check(rts_n, 1'h0);
    end
    rx_begin();
    step(3);
    check(rts_n, 1'h1);
    rx_end(rnd());
    check(lvl, ufc_pkg::FIFO_DEPTH);
    rd_pop();
    check(rts_n, 1'h0);
    // stop and resume with five-bit words
    cfg(8'h00, 8'h20, ufc_pkg::TRIG_14, 1'h0, 1'h1, 1'h1);
    @(posedge mclk_i);
    line_control_reg <= 2'h0;
    wchar(2'h2, 8'h13);
    wchar(2'h0, 8'h11);
    rx_char(8'hF3);
    check(ff, 1'h1);
    check(irq, 1'h1);
    check(src, ufc_pkg::SRC_XOFF);
    check(lvl, 8'h00);
    s0 = int'(sent);
    tx_push(8'h55);
    step(30);
    check(sent, 8'(s0));
    rx_char(8'h11);
    check(ff, 1'h0);
    step(20);
    check(sent, 8'(s0 + 1));
    check(lvl, 8'h00);
    // pair mode, interrupt masked
    cfg(8'h00, 8'h00, ufc_pkg::TRIG_14, 1'h1, 1'h1, 1'h0);
    wchar(2'h2, 8'h13);
    wchar(2'h3, 8'h14);
    rx_char(8'h13);
    rx_char(8'h41);
    check(ff, 1'h0);
    rx_char(8'h13);
    rx_char(8'h14);
    check(ff, 1'h1);
    check(irq, 1'h0);
    // special character is kept
    cfg(8'h20, 8'h20, ufc_pkg::TRIG_14, 1'h0, 1'h0, 1'h0);
    wchar(2'h3, 8'h5A);
    rx_char(8'h5A);
    check(sf, 1'h1);
    check(head, 8'h5A);
    // flow characters sent on fill changes
    cfg(8'h00, 8'h00, ufc_pkg::TRIG_1, 1'h0, 1'h0, 1'h1);
    wchar(2'h2, 8'h13);
    wchar(2'h0, 8'h11);
    rx_char(rnd());
    step(20);
    check(last, 8'h13);
    rd_pop();
    step(20);
    check(last, 8'h11);
    // clear-to-send gating
    cfg(8'hC0, 8'h80, ufc_pkg::TRIG_14, 1'h0, 1'h0, 1'h0);
    @(posedge mclk_i);
    hold <= 1'h1;
    step(3);
    tx_push(8'h31);
    tx_push(8'h32);
    step(20);
    check(sent, 8'h00);
    check(irq, 1'h0);
    @(posedge mclk_i);
    hold <= 1'h0;
    step(5);
    check(sent, 8'h01);
    @(posedge mclk_i);
    hold <= 1'h1;
    step(40);
    check(sent, 8'h01);
    check(irq, 1'h0);
    @(posedge mclk_i);
    hold <= 1'h0;
    step(10);
    check(sent, 8'h02);
    // receive time-out: 4 chars of 2 bits at 16 ticks
    cfg(8'h00, 8'hFF, ufc_pkg::TRIG_14, 1'h0, 1'h0, 1'h0);
    rx_char(rnd());
    step(100);
    check(src == ufc_pkg::SRC_TOUT, 1'h0);
    step(40);
    check(src, ufc_pkg::SRC_TOUT);
    rd_pop();
    step(300);
    check(src == ufc_pkg::SRC_TOUT, 1'h0);
    finish_test();
  end
endmodule : testbench
